//--- core/csfr_regs.svh
// register offsets, field positions and reset values of the core register bank
`ifndef CSFR_REGS_SVH
`define CSFR_REGS_SVH
`define CSFR_ADR_PORT0    8'h80
`define CSFR_ADR_SP       8'h81
`define CSFR_ADR_DPL      8'h82
`define CSFR_ADR_DPH      8'h83
`define CSFR_ADR_ADPL     8'h84
`define CSFR_ADR_ADPH     8'h85
`define CSFR_ADR_PSEL     8'h86
`define CSFR_ADR_PWR      8'h87
`define CSFR_ADR_TRUN     8'h88
`define CSFR_ADR_TMODE    8'h89
`define CSFR_ADR_PMGMT    8'hC4
`define CSFR_SFR_BASE     8'h80
`define CSFR_BIT_SFR      7
`define CSFR_PSEL_MASK    8'h01
`define CSFR_PWR_MASK     8'hF3
`define CSFR_PMGMT_MASK   8'h01
`define CSFR_PWR_BAUD     7
`define CSFR_PWR_FEEN     6
`define CSFR_PWR_PD       1
`define CSFR_PWR_IDL      0
`define CSFR_T_TF1        7
`define CSFR_T_TR1        6
`define CSFR_T_TF0        5
`define CSFR_T_TR0        4
`define CSFR_T_IE1        3
`define CSFR_T_IT1        2
`define CSFR_T_IE0        1
`define CSFR_T_IT0        0
`define CSFR_M_GATE0      3
`define CSFR_M_CT0        2
`define CSFR_M_GATE1      7
`define CSFR_M_CT1        6
`define CSFR_SRAM_TOP     16'h03FF
`define CSFR_ROM_TOP      16'h7FFF
`define CSFR_RST_PORT0    8'hFF
`define CSFR_RST_SP       8'h07
`define CSFR_RST_ZERO     8'h00
`define CSFR_ALL_ONES     8'hFF
`define CSFR_SRAM_MC      2'h2
`endif

//--- core/csfr_pkg.sv
// types shared by the core register bank
package csfr_pkg;
  // register bus request from the core
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       bit_wr;
    logic       direct;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic       bit_val;
    logic [7:0] wdata;
  } csfr_req_t;
  // external data move request
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] addr;
  } csfr_xmov_t;
  // timer and external interrupt event strobes
  typedef struct packed {
    logic ovf0;
    logic ovf1;
    logic vec_t0;
    logic vec_t1;
    logic vec_x0;
    logic vec_x1;
  } csfr_evt_t;
  // move sequencer states
  typedef enum logic [2:0] {
    CSFR_IDLE = 3'b001,
    CSFR_SRAM = 3'b010,
    CSFR_EXT  = 3'b100
  } csfr_mst_t;
  // whole register state
  typedef struct packed {
    logic [7:0]  port0;
    logic [7:0]  sp;
    logic [7:0]  data_pointer_low;
    logic [7:0]  data_pointer_high;
    logic [7:0]  adpl;
    logic [7:0]  adph;
    logic        psel;
    logic [7:0]  pwr;
    logic [7:0]  trun;
    logic [7:0]  tmode;
    logic        sram_en;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [1:0]  x0_s;
    logic [1:0]  x1_s;
    logic [1:0]  t0_s;
    logic [1:0]  t1_s;
    logic        x0_d;
    logic        x1_d;
    logic        t0_d;
    logic        t1_d;
    logic        cnt0;
    logic        cnt1;
    csfr_mst_t   mst;
    logic [1:0]  mcnt;
    logic        sram_sel;
    logic        ext_sel;
    logic        mdone;
    logic        code_ext;
    logic [15:0] active_data_pointer;
    logic        cpu_halt;
    logic        all_halt;
    logic        baud_x2;
    logic        fe_mode;
    logic [7:0]  p0_s1;
    logic [7:0]  p0_s2;
    logic [7:0]  pz_out;
    logic [7:0]  pz_oe;
  } csfr_state_t;
endpackage : csfr_pkg

//--- core/csfr_bank.sv
// core special function register bank with data move and code fetch decode
`timescale 1ns/1ps
`include "csfr_regs.svh"
// Function
// - on-chip sram enable clears at reset so data moves go external
// - enabled sram serves addresses up to 03FF, higher go external
// - disabled sram sends every data move address external
// - code fetches above 32 KB on-chip rom go to external memory
// - registers live at 80-FF and answer only direct accesses
// - only registers ending in 0 or 8 accept single bit writes
// - unimplemented addresses and bits read as one, except pointer select bits one to seven
// - port zero open drain, carries low address during external access
// - pointer select bit zero picks alternate or standard pointer pair
// - pointer select bits one to seven read zero
// - alternate pointer bytes also serve as plain storage
// - baud doubler bit doubles serial rate in modes one to three
// - frame error enable makes serial bit seven a framing flag
// - two user flags are plain storage
// - powerdown request stops all clocks
// - cpu halt request stops cpu clock, peripherals keep running
// - overflow flags set by hardware, cleared on vectoring or software
// - run bits are software only and start or stop timers
// - external flags set by pin; edge cleared on vector, level follows
// - type bit selects falling edge or low level trigger
// - gate bit requires pin high as well as run bit
// - count source selects internal clock or timer pin falling edges
// - on-chip sram moves always take two machine cycles
module csfr_bank (
  // clock, reset and enable
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_srst,
  input  wire logic                 i_ce,
  // register access from the core
  input  wire csfr_pkg::csfr_req_t  i_req,
  // data move and code fetch from the core
  input  wire csfr_pkg::csfr_xmov_t i_xmov,
  input  wire logic [15:0]          i_code_addr,
  input  wire logic                 i_mc_tick,
  // timer and interrupt events
  input  wire csfr_pkg::csfr_evt_t  i_evt,
  // pins from outside
  input  wire logic                 i_ext_int0_n,
  input  wire logic                 i_ext_int1_n,
  input  wire logic                 i_tpin0,
  input  wire logic                 i_tpin1,
  input  wire logic [7:0]           i_port_zero_in,
  // register read answer
  output logic [7:0]                o_rdata,
  output logic                      o_rvalid,
  // decode results
  output logic                      o_sram_sel,
  output logic                      o_ext_sel,
  output logic                      o_mdone,
  output logic                      o_code_ext,
  output logic [15:0]               o_active_data_pointer,
  // timer control
  output logic                      o_cnt0,
  output logic                      o_cnt1,
  output logic [7:0]                o_trun,
  output logic [7:0]                o_tmode,
  // power and serial control
  output logic                      o_cpu_halt,
  output logic                      o_all_halt,
  output logic                      o_baud_x2,
  output logic                      o_fe_mode,
  // port zero pin drive
  output logic [7:0]                o_port_zero_out,
  output logic [7:0]                o_port_zero_oe
);
  import csfr_pkg::*;

  csfr_state_t st;
  csfr_state_t next_st;
  logic        acc_ok;
  logic        bit_ok;
  logic [7:0]  cur;
  logic [7:0]  wv;
  logic        x0_fall;
  logic        x1_fall;
  logic        t0_fall;
  logic        t1_fall;
  logic        in_sram;

  // next state of the whole bank
  always_comb begin
    next_st = st;
    acc_ok  = i_req.direct && i_req.addr[`CSFR_BIT_SFR];
    bit_ok  = i_req.bit_wr && (i_req.addr[2:0] == 3'h0);
    // current value of the addressed register, unknown bits high except the select register's upper bits
    if (i_req.addr == `CSFR_ADR_PORT0) begin
      cur = st.p0_s2; // pins, not the latch
    end else if (i_req.addr == `CSFR_ADR_SP) begin
      cur = st.sp;
    end else if (i_req.addr == `CSFR_ADR_DPL) begin
      cur = st.data_pointer_low;
    end else if (i_req.addr == `CSFR_ADR_DPH) begin
      cur = st.data_pointer_high;
    end else if (i_req.addr == `CSFR_ADR_ADPL) begin
      cur = st.adpl;
    end else if (i_req.addr == `CSFR_ADR_ADPH) begin
      cur = st.adph;
    end else if (i_req.addr == `CSFR_ADR_PSEL) begin
      cur = {7'h00, st.psel};
    end else if (i_req.addr == `CSFR_ADR_PWR) begin
      cur = st.pwr | ~`CSFR_PWR_MASK;
    end else if (i_req.addr == `CSFR_ADR_TRUN) begin
      cur = st.trun;
    end else if (i_req.addr == `CSFR_ADR_TMODE) begin
      cur = st.tmode;
    end else if (i_req.addr == `CSFR_ADR_PMGMT) begin
      cur = {7'h7F, st.sram_en};
    end else begin
      cur = `CSFR_ALL_ONES;
    end
    // bit writes merge one bit into the current value, the latch for port zero
    wv = i_req.wdata;
    if (bit_ok) begin
      wv = (i_req.addr == `CSFR_ADR_PORT0) ? st.port0 : cur;
      wv[i_req.bit_sel] = i_req.bit_val;
    end
    // read answer one cycle after the request
    next_st.rvalid = i_req.rd && acc_ok;
    next_st.rdata  = acc_ok ? cur : `CSFR_ALL_ONES;
    // pin synchronisers; second stage feeds edge detect
    next_st.x0_s = {st.x0_s[0], i_ext_int0_n};
    next_st.x1_s = {st.x1_s[0], i_ext_int1_n};
    next_st.t0_s = {st.t0_s[0], i_tpin0};
    next_st.t1_s = {st.t1_s[0], i_tpin1};
    // port zero pins are outside levels too, so they cross two flops
    next_st.p0_s1 = i_port_zero_in;
    next_st.p0_s2 = st.p0_s1;
    next_st.x0_d = st.x0_s[1];
    next_st.x1_d = st.x1_s[1];
    next_st.t0_d = st.t0_s[1];
    next_st.t1_d = st.t1_s[1];
    x0_fall = st.x0_d && !st.x0_s[1];
    x1_fall = st.x1_d && !st.x1_s[1];
    t0_fall = st.t0_d && !st.t0_s[1];
    t1_fall = st.t1_d && !st.t1_s[1];
    // software writes; plain writes need addresses, bit writes need 0 or 8
    if (acc_ok && (i_req.wr || bit_ok)) begin
      if (i_req.addr == `CSFR_ADR_PORT0) begin
        next_st.port0 = wv;
      end else if (i_req.addr == `CSFR_ADR_SP) begin
        next_st.sp = wv;
      end else if (i_req.addr == `CSFR_ADR_DPL) begin
        next_st.data_pointer_low = wv;
      end else if (i_req.addr == `CSFR_ADR_DPH) begin
        next_st.data_pointer_high = wv;
      end else if (i_req.addr == `CSFR_ADR_ADPL) begin
        next_st.adpl = wv;
      end else if (i_req.addr == `CSFR_ADR_ADPH) begin
        next_st.adph = wv;
      end else if (i_req.addr == `CSFR_ADR_PSEL) begin
        next_st.psel = wv[0];
      end else if (i_req.addr == `CSFR_ADR_PWR) begin
        next_st.pwr = wv & `CSFR_PWR_MASK;
      end else if (i_req.addr == `CSFR_ADR_TRUN) begin
        next_st.trun = wv;
      end else if (i_req.addr == `CSFR_ADR_TMODE) begin
        next_st.tmode = wv;
      end else if (i_req.addr == `CSFR_ADR_PMGMT) begin
        next_st.sram_en = wv[0];
      end
    end
    // hardware clears on vectoring, then sets win over every clear
    if (i_evt.vec_t0) next_st.trun[`CSFR_T_TF0] = 1'b0;
    if (i_evt.vec_t1) next_st.trun[`CSFR_T_TF1] = 1'b0;
    if (i_evt.ovf0) next_st.trun[`CSFR_T_TF0] = 1'b1;
    if (i_evt.ovf1) next_st.trun[`CSFR_T_TF1] = 1'b1;
    // external flags: edge mode sticky, level mode follows the pin
    if (next_st.trun[`CSFR_T_IT0]) begin
      if (i_evt.vec_x0) next_st.trun[`CSFR_T_IE0] = 1'b0;
      if (x0_fall) next_st.trun[`CSFR_T_IE0] = 1'b1;
    end else begin
      next_st.trun[`CSFR_T_IE0] = !st.x0_s[1];
    end
    if (next_st.trun[`CSFR_T_IT1]) begin
      if (i_evt.vec_x1) next_st.trun[`CSFR_T_IE1] = 1'b0;
      if (x1_fall) next_st.trun[`CSFR_T_IE1] = 1'b1;
    end else begin
      next_st.trun[`CSFR_T_IE1] = !st.x1_s[1];
    end
    // count enables from run, gate and source bits
    next_st.cnt0 = st.trun[`CSFR_T_TR0]
      && (!st.tmode[`CSFR_M_GATE0] || st.x0_s[1])
      && (st.tmode[`CSFR_M_CT0] ? t0_fall : i_mc_tick);
    next_st.cnt1 = st.trun[`CSFR_T_TR1]
      && (!st.tmode[`CSFR_M_GATE1] || st.x1_s[1])
      && (st.tmode[`CSFR_M_CT1] ? t1_fall : i_mc_tick);
    // power and serial mode levels
    next_st.all_halt = st.pwr[`CSFR_PWR_PD];
    next_st.cpu_halt = st.pwr[`CSFR_PWR_IDL] || st.pwr[`CSFR_PWR_PD];
    next_st.baud_x2  = st.pwr[`CSFR_PWR_BAUD];
    next_st.fe_mode  = st.pwr[`CSFR_PWR_FEEN];
    // active pointer follows the latest select value
    next_st.active_data_pointer = next_st.psel ? {next_st.adph, next_st.adpl}
                                : {next_st.data_pointer_high, next_st.data_pointer_low};
    // code fetch spill above on-chip rom
    next_st.code_ext = i_code_addr > `CSFR_ROM_TOP;
    // data move sequencer
    in_sram = st.sram_en && (i_xmov.addr <= `CSFR_SRAM_TOP);
    next_st.mdone = 1'b0;
    case (st.mst)
      CSFR_IDLE: begin
        if (i_xmov.req && in_sram) begin
          next_st.mst      = CSFR_SRAM;
          next_st.sram_sel = 1'b1;
          next_st.mcnt     = 2'h0;
        end else if (i_xmov.req) begin
          next_st.mst     = CSFR_EXT;
          next_st.ext_sel = 1'b1;
        end
      end
      CSFR_SRAM: begin
        // fixed two machine cycles, stretch setting ignored
        if (i_mc_tick) begin
          next_st.mcnt = st.mcnt + 2'h1;
          if (st.mcnt + 2'h1 == `CSFR_SRAM_MC) begin
            next_st.mst      = CSFR_IDLE;
            next_st.sram_sel = 1'b0;
            next_st.mdone    = 1'b1;
          end
        end
      end
      CSFR_EXT: begin
        // external timing is owned by the bus sequencer; held while requested
        if (!i_xmov.req) begin
          next_st.mst     = CSFR_IDLE;
          next_st.ext_sel = 1'b0;
          next_st.mdone   = 1'b1;
        end
      end
      default: begin
        next_st.mst = CSFR_IDLE;
      end
    endcase
    // port zero: low address byte while a move runs external, latch drive otherwise;
    // limitation: the data phase and its strobes belong to the bus sequencer
    if (next_st.ext_sel) begin
      next_st.pz_out = i_xmov.addr[7:0];
      next_st.pz_oe  = `CSFR_ALL_ONES;
    end else begin
      next_st.pz_out = `CSFR_RST_ZERO;
      next_st.pz_oe  = ~next_st.port0;
    end
  end

  // register the bank; clock enable freezes all of it
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st          <= '0;
      st.port0    <= `CSFR_RST_PORT0;
      st.sp       <= `CSFR_RST_SP;
      st.rdata    <= `CSFR_ALL_ONES;
      st.x0_s     <= 2'h3;
      st.x1_s     <= 2'h3;
      st.t0_s     <= 2'h3;
      st.t1_s     <= 2'h3;
      st.x0_d     <= 1'b1;
      st.x1_d     <= 1'b1;
      st.t0_d     <= 1'b1;
      st.t1_d     <= 1'b1;
      st.mst      <= CSFR_IDLE;
      st.sram_en  <= 1'b0;
      // pin flops keep shifting so the first port read after reset is settled
      st.p0_s1    <= next_st.p0_s1;
      st.p0_s2    <= next_st.p0_s2;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign o_rdata               = st.rdata;
  assign o_rvalid              = st.rvalid;
  assign o_sram_sel            = st.sram_sel;
  assign o_ext_sel             = st.ext_sel;
  assign o_mdone               = st.mdone;
  assign o_code_ext            = st.code_ext;
  assign o_active_data_pointer = st.active_data_pointer;
  assign o_cnt0                = st.cnt0;
  assign o_cnt1                = st.cnt1;
  assign o_trun                = st.trun;
  assign o_tmode               = st.tmode;
  assign o_cpu_halt            = st.cpu_halt;
  assign o_all_halt            = st.all_halt;
  assign o_baud_x2             = st.baud_x2;
  assign o_fe_mode             = st.fe_mode;
  // open drain: a zero latch bit pulls low, a one releases the pin
  assign o_port_zero_out       = st.pz_out;
  assign o_port_zero_oe        = st.pz_oe;
endmodule : csfr_bank

//--- bench/csfr_bank_assertions.sv
// port-level checks of the core register bank
`timescale 1ns/1ps
module csfr_bank_assertions (
  // clock and control
  input wire logic                 i_clk_sys,
  input wire logic                 i_srst,
  input wire logic                 i_ce,
  // requests
  input wire csfr_pkg::csfr_req_t  i_req,
  input wire csfr_pkg::csfr_xmov_t i_xmov,
  input wire logic [15:0]          i_code_addr,
  input wire logic                 i_mc_tick,
  // answers
  input wire logic [7:0]           o_rdata,
  input wire logic                 o_rvalid,
  input wire logic                 o_sram_sel,
  input wire logic                 o_ext_sel,
  input wire logic                 o_mdone,
  input wire logic                 o_code_ext,
  input wire logic                 o_cnt0,
  input wire logic [7:0]           o_trun,
  input wire logic [7:0]           o_tmode,
  input wire logic                 o_all_halt,
  input wire logic                 o_baud_x2,
  input wire logic                 o_fe_mode
);
  import csfr_pkg::*;
  logic [2:0]  tick_cnt;
  logic        rd_ok;
  logic [7:0]  rd_addr;
  logic [15:0] mv_addr;
  // machine ticks seen while the sram serves a move
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !o_sram_sel) begin
      tick_cnt <= 3'h0;
    end else if (i_mc_tick && i_ce) begin
      tick_cnt <= tick_cnt + 3'h1;
    end
  end
  // request decode shared by several checks
  assign rd_ok   = i_ce && i_req.rd && i_req.direct && i_req.addr[7];
  assign rd_addr = i_req.addr;
  assign mv_addr = i_xmov.addr;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  sequence s_sram_end;
    o_mdone && $past(o_sram_sel);
  endsequence
  chk_reset_quiet: assert property ($fell(i_srst) |-> !o_sram_sel && !o_ext_sel)
    else $error("selects active after reset");
  chk_rd_answer: assert property (rd_ok |=> o_rvalid)
    else $error("direct read not answered");
  chk_indirect_refused: assert property (i_ce && i_req.rd && !i_req.direct |=>
    !o_rvalid && o_rdata == 8'hFF)
    else $error("indirect read answered");
  chk_sel_exclusive: assert property (!(o_sram_sel && o_ext_sel))
    else $error("sram and external both selected");
  chk_sram_range: assert property ($rose(o_sram_sel) |-> $past(mv_addr) <= 16'h03FF)
    else $error("sram served address above range");
  chk_sram_two_mc: assert property (s_sram_end |-> tick_cnt == 3'h2)
    else $error("sram move not two machine cycles");
  chk_code_spill: assert property (i_ce |=> o_code_ext == ($past(i_code_addr) > 16'h7FFF))
    else $error("code spill decode wrong");
  chk_select_reserved: assert property (o_rvalid && $past(rd_addr) == 8'h86 |->
    o_rdata[7:1] == 7'h00)
    else $error("select upper bits not zero");
  chk_power_readback: assert property (o_rvalid && $past(rd_addr) == 8'h87 |->
    o_rdata[3:2] == 2'h3 && o_rdata[7] == o_baud_x2 && o_rdata[6] == o_fe_mode)
    else $error("power register readback wrong");
  chk_timer_count: assert property (i_mc_tick && o_trun[4] && o_tmode[3:2] == 2'h0 &&
    !o_all_halt |-> ##[1:3] o_cnt0)
    else $error("running timer did not count");
endmodule : csfr_bank_assertions

//--- bench/csfr_port_zero_model.sv
// far side of port zero: outside level unless the bank pulls a pin
`timescale 1ns/1ps
module csfr_port_zero_model #(
  parameter logic [7:0] EXT_LEVEL = 8'hA5
) (
  // drive from the bank
  input  wire logic [7:0] i_port_zero_out,
  input  wire logic [7:0] i_port_zero_oe,
  // resolved pin levels
  output logic [7:0]      o_port_zero_pin
);
  // open drain: a pin not driven shows the outside device level
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      o_port_zero_pin[b] = i_port_zero_oe[b] ? i_port_zero_out[b] : EXT_LEVEL[b];
    end
  end
endmodule : csfr_port_zero_model

//--- bench/test_core_sfr_and_data_memory_decode.sv
// self-checking bench of the core register bank
`timescale 1ns/1ps
module test_core_sfr_and_data_memory_decode;
  import csfr_pkg::*;
  logic clk_sys, srst, ce, mc_tick, int0_n, int1_n, tpin0, tpin1;
  logic rvalid, sram_sel, ext_sel, mdone, code_ext, cnt0, cnt1, cpu_halt, all_halt;
  logic baud_x2, fe_mode;
  logic [7:0] rdata, trun, tmode, pz_out, pz_oe, pz_pin;
  logic [15:0] code_addr, adp;
  logic [1:0] tk;
  logic [7:0] c0, c1;
  csfr_req_t req;
  csfr_xmov_t xmov;
  csfr_evt_t evt;
  int failures, compares, cyc, n;
  logic [7:0] ra [12] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88,
                          8'h89, 8'hC4, 8'h8F};
  logic [7:0] re [12] = '{8'hA5, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h00,
                          8'h00, 8'hFE, 8'hFF};
  csfr_bank i_csfr_bank (.i_clk_sys(clk_sys), .i_srst(srst), .i_ce(ce), .i_req(req),
    .i_xmov(xmov), .i_code_addr(code_addr), .i_mc_tick(mc_tick), .i_evt(evt),
    .i_ext_int0_n(int0_n), .i_ext_int1_n(int1_n), .i_tpin0(tpin0), .i_tpin1(tpin1),
    .i_port_zero_in(pz_pin), .o_rdata(rdata), .o_rvalid(rvalid), .o_sram_sel(sram_sel),
    .o_ext_sel(ext_sel), .o_mdone(mdone), .o_code_ext(code_ext),
    .o_active_data_pointer(adp), .o_cnt0(cnt0), .o_cnt1(cnt1), .o_trun(trun),
    .o_tmode(tmode), .o_cpu_halt(cpu_halt), .o_all_halt(all_halt), .o_baud_x2(baud_x2),
    .o_fe_mode(fe_mode), .o_port_zero_out(pz_out), .o_port_zero_oe(pz_oe));
  csfr_port_zero_model i_csfr_port_zero_model (.i_port_zero_out(pz_out),
    .i_port_zero_oe(pz_oe), .o_port_zero_pin(pz_pin));
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // machine tick every fourth clock, and the hang guard
  always @(posedge clk_sys) begin
    tk <= tk + 2'h1;
    mc_tick <= (tk == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // one register request; d carries bit select and bit value for bit writes
  task automatic acc(input logic r, input logic bw, input logic dir, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{rd: r, wr: !r && !bw, bit_wr: bw, direct: dir, addr: a, bit_sel: d[2:0],
             bit_val: d[3], wdata: d};
    @(posedge clk_sys);
    req <= '0;
    #1;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b0, 1'b0, 1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b1, 1'b0, 1'b1, a, 8'h00);
    cmp({7'h00, rvalid, rdata}, {8'h01, e});
  endtask : rd
  // registered level outputs need one more edge
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic mv(input logic [15:0] a, input logic sram);
    @(posedge clk_sys);
    xmov <= '{req: 1'b1, wr: a[0], addr: a};
    @(posedge clk_sys);
    #1;
    cmp({sram_sel, ext_sel}, {sram, !sram});
    cmp({pz_out, pz_oe}, sram ? 16'h0000 : {a[7:0], 8'hFF});
    if (!sram) repeat (3) @(posedge clk_sys);
    if (!sram) xmov.req <= 1'b0;
    n = 0;
    while (mdone !== 1'b1 && n < 24) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    xmov <= '0;
    cmp(mdone, 1'b1);
  endtask : mv
  task automatic pulse(input csfr_evt_t e);
    @(posedge clk_sys);
    evt <= e;
    @(posedge clk_sys);
    evt <= '0;
    settle();
  endtask : pulse
  task automatic pin0(input logic v);
    @(posedge clk_sys);
    int0_n <= v;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : pin0
  // enable pulses of both timers over sixteen clocks
  task automatic count(output logic [7:0] s0, output logic [7:0] s1);
    s0 = 8'h00;
    s1 = 8'h00;
    repeat (16) begin
      @(posedge clk_sys);
      #1;
      s0 = s0 + {7'h00, cnt0};
      s1 = s1 + {7'h00, cnt1};
    end
  endtask : count
  task automatic rst();
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
  endtask : rst
  // main sequence
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    req = '0;
    xmov = '0;
    evt = '0;
    code_addr = 16'h0000;
    {mc_tick, tk, cyc, failures, compares} = '0;
    {int0_n, int1_n, tpin0, tpin1} = 4'hF;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    foreach (ra[k]) rd(ra[k], re[k]);
    mv(16'h0010, 1'b0);
    wr(8'hC4, 8'h01);
    rd(8'hC4, 8'hFF);
    mv(16'h03FF, 1'b1);
    mv(16'h0400, 1'b0);
    foreach (ra[k]) if (k > 1 && k < 6) wr(ra[k], 8'h12 + 8'h22 * k[7:0]);
    wr(8'h86, 8'hFF);
    cmp(adp, 16'hBC9A);
    rd(8'h86, 8'h01);
    wr(8'h86, 8'h00);
    cmp(adp, 16'h7856);
    rd(8'h85, 8'hBC);
    acc(1'b0, 1'b0, 1'b0, 8'h82, 8'hEE);
    rd(8'h82, 8'h56);
    acc(1'b1, 1'b0, 1'b0, 8'h82, 8'h00);
    cmp({7'h00, rvalid, rdata}, 16'h00FF);
    foreach (ra[k]) begin
      @(posedge clk_sys);
      code_addr <= {ra[k][0], ra[k][1], 14'h3FFF} + {15'h0, ra[k][2]};
      @(posedge clk_sys);
      #1;
      cmp(code_ext, ({ra[k][0], ra[k][1], 14'h3FFF} + {15'h0, ra[k][2]}) > 16'h7FFF);
    end
    wr(8'h87, 8'hF0);
    rd(8'h87, 8'hFC);
    acc(1'b0, 1'b1, 1'b1, 8'h87, 8'h07);
    rd(8'h87, 8'hFC);
    settle();
    cmp({baud_x2, fe_mode}, 2'h3);
    wr(8'h87, 8'h01);
    acc(1'b0, 1'b1, 1'b1, 8'h88, 8'h0C);
    settle();
    cmp({cpu_halt, all_halt, trun}, 10'h210);
    n = 0;
    while (cnt0 !== 1'b1 && n < 16) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    cmp(cnt0, 1'b1);
    rst();
    acc(1'b0, 1'b1, 1'b1, 8'h88, 8'h08);
    pin0(1'b0);
    pin0(1'b1);
    cmp(trun, 8'h03);
    pulse(6'h02);
    cmp(trun, 8'h01);
    acc(1'b0, 1'b1, 1'b1, 8'h88, 8'h00);
    pin0(1'b0);
    cmp(trun, 8'h02);
    pin0(1'b1);
    cmp(trun, 8'h00);
    pulse(6'h20);
    cmp(trun, 8'h20);
    pulse(6'h08);
    pulse(6'h10);
    cmp(trun, 8'h80);
    wr(8'h88, 8'h00);
    rd(8'h88, 8'h00);
    // timer 0 gated by its pin, timer 1 counting its pin's falling edges
    wr(8'h89, 8'h48);
    cmp(tmode, 8'h48);
    wr(8'h88, 8'h50);
    pin0(1'b0);
    count(c0, c1);
    cmp({c0, c1}, 16'h0000);
    pin0(1'b1);
    @(posedge clk_sys);
    tpin1 <= 1'b0;
    count(c0, c1);
    cmp({c0, c1}, 16'h0401);
    wr(8'h80, 8'h0F);
    cmp(pz_oe, 16'h00F0);
    settle();
    rd(8'h80, 8'h05);
    // a frozen bank takes no write
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(8'h81, 8'h55);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd(8'h81, 8'h07);
    wr(8'h87, 8'h02);
    settle();
    cmp(all_halt, 1'b1);
    end_sim();
  end
endmodule : test_core_sfr_and_data_memory_decode
bind csfr_bank csfr_bank_assertions i_csfr_bank_assertions (.i_clk_sys, .i_srst, .i_ce,
  .i_req, .i_xmov, .i_code_addr, .i_mc_tick, .o_rdata, .o_rvalid, .o_sram_sel, .o_ext_sel,
  .o_mdone, .o_code_ext, .o_cnt0, .o_trun, .o_tmode, .o_all_halt, .o_baud_x2, .o_fe_mode);
